// file: logic/nisr_top.sv
`timescale 1ns/10ps
// Summary of operation
// - address 20h after 90h reads exactly the four signature bytes
// - host accepts a copy only if id xor inverse is all ones
// - after status polling host sends 00h before reading data again
// - bytes 254-255 checksum; host validates each copy with it
// - status mode persists; host sends 00h before data cycles
// - enhanced status takes three row address cycles
// - host never issues enhanced status during reset
// - no commands for 2 ms after power-up; write protect held low
module nisr_top
  import nisr_pkg::*;
#(
  parameter int unsigned P_PWR_CYC = PWR_CYC
)
(
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        en_i,
  // user request and answer
  input  wire nisr_req_s   req_i,
  output nisr_res_s        res_o,
  // flash pins
  output nisr_pins_s       pins_o,
  input  wire logic [7:0]  io_i,
  input  wire logic        rb_i
);

  logic [1:0]  rst_q_r;
  logic        rst_n;
  nisr_state_s r;
  nisr_state_s n;
  logic [15:0] crc_step;

  // reset release through two flops
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_q_r <= 2'b00;
    else
      rst_q_r <= {rst_q_r[0], 1'b1};
  end
  assign rst_n = rst_q_r[1];

  // checksum of the captured byte
  nisr_crc16 u_crc (
    .crc_i  (r.crc),
    .byte_i (r.io_s2),
    .crc_o  (crc_step)
  );

  // sequencer next state
  always_comb
  begin
    logic [7:0] b;
    logic       fin;
    logic       okv;
    logic [7:0] abyte;
    b     = r.io_s2;
    fin   = 1'b0;
    okv   = 1'b0;
    abyte = ADDR_ZERO;
    n = r;
    n.res.done     = 1'b0;
    n.res.byte_vld = 1'b0;
    n.io_s1 = io_i;
    n.io_s2 = r.io_s1;
    n.rb_s1 = rb_i;
    n.rb_s2 = r.rb_s1;
    case (r.op)
      OP_SIG:        abyte = ADDR_SIG;
      OP_ID:         abyte = ADDR_ID;
      OP_STATUS_ENH: abyte = r.row[{r.aidx, 3'b000} +: 8];
      default:       abyte = ADDR_ZERO;
    endcase
    case (r.st)
      S_PWR:
      begin
        // quiet period, write protect held low
        if (r.cnt == 16'(P_PWR_CYC - 1))
        begin
          n.st = S_IDLE;
          n.cnt = 16'h0000;
          n.pins.wp_n = 1'b1;
          n.res.rdy = 1'b1;
        end
        else
          n.cnt = r.cnt + 16'h0001;
      end
      S_IDLE:
      begin
        // enhanced status refused while reset is pending
        if (req_i.go && !(req_i.op == OP_STATUS_ENH && r.rst_busy))
        begin
          n.op = req_i.op;
          n.row = req_i.row;
          n.res.rdy = 1'b0;
          n.res.ok = 1'b0;
          n.pins.ce_n = 1'b0;
          n.st = S_CMD;
          n.ph = 2'd0;
          n.aidx = 2'd0;
          n.bidx = 8'h00;
          n.copy = 4'h0;
          n.chk_ok = 1'b1;
          n.crc = CRC_INIT;
          case (req_i.op)
            OP_UNIQ:       n.cmd = CMD_UNIQ;
            OP_PARAM:      n.cmd = CMD_PARAM;
            OP_STATUS:     n.cmd = CMD_STATUS;
            OP_STATUS_ENH: n.cmd = CMD_STATUS_ENH;
            OP_RESET:      n.cmd = CMD_RESET;
            default:       n.cmd = CMD_ID;
          endcase
          n.rst_busy = (req_i.op == OP_RESET);
        end
      end
      S_CMD, S_ADR:
      begin
        // setup, strobe low, strobe high, release
        case (r.ph)
          2'd0:
          begin
            n.pins.cle = (r.st == S_CMD);
            n.pins.ale = (r.st == S_ADR);
            n.pins.io_out = (r.st == S_CMD) ? r.cmd : abyte;
            n.pins.io_oe = 1'b1;
            n.ph = 2'd1;
          end
          2'd1:
          begin
            n.pins.we_n = 1'b0;
            n.ph = 2'd2;
          end
          2'd2:
          begin
            n.pins.we_n = 1'b1;
            n.ph = 2'd3;
          end
          default:
          begin
            n.pins.cle = 1'b0;
            n.pins.ale = 1'b0;
            n.pins.io_oe = 1'b0;
            n.ph = 2'd0;
            n.cnt = 16'h0000;
            if (r.st == S_ADR)
            begin
              // three row cycles for enhanced status
              if (r.op == OP_STATUS_ENH && r.aidx != 2'(ADDR_ROW_CYC - 1))
              begin
                n.aidx = r.aidx + 2'd1;
              end
              else
              begin
                n.st = S_WAIT;
                n.nx = (r.op == OP_UNIQ || r.op == OP_PARAM) ? S_CMD : S_READ;
                n.cmd = CMD_STATUS;
              end
            end
            else if (r.cmd == CMD_READ)
              n.st = S_READ;
            else if (r.cmd == CMD_STATUS && r.op != OP_STATUS)
            begin
              n.st = S_WAIT;
              n.nx = S_POLL_RD;
            end
            else if (r.cmd == CMD_STATUS)
            begin
              n.st = S_WAIT;
              n.nx = S_READ;
            end
            else if (r.cmd == CMD_RESET)
            begin
              n.st = S_WAIT;
              n.nx = S_RBWAIT;
            end
            else
              n.st = S_ADR;
          end
        endcase
      end
      S_WAIT:
      begin
        if (r.cnt == 16'(WB_CYC - 1))
        begin
          n.cnt = 16'h0000;
          n.st = r.nx;
        end
        else
          n.cnt = r.cnt + 16'h0001;
      end
      S_POLL_RD, S_READ:
      begin
        if (r.ph == 2'd0)
        begin
          n.pins.re_n = 1'b0;
          if (r.cnt == 16'(RD_LOW_CYC)) // two sync stages: sample after the last low cycle
          begin
            n.cnt = 16'h0000;
            n.pins.re_n = 1'b1;
            n.ph = 2'd1;
            if (r.st == S_POLL_RD)
            begin
              // ready seen: leave status mode with 00h
              if (b[ST_READY_BIT])
              begin
                n.st = S_CMD;
                n.cmd = CMD_READ;
                n.ph = 2'd0;
              end
            end
            else
            begin
              // pointer advances once per read cycle
              n.res.byte_vld = 1'b1;
              n.res.byte_val = b;
              n.bidx = r.bidx + 8'h01;
              case (r.op)
                OP_ID:
                begin
                  fin = (r.bidx == 8'(ID_LEN - 1));
                  okv = 1'b1;
                end
                OP_SIG:
                begin
                  // only four signature bytes are meaningful
                  n.chk_ok = r.chk_ok && (b == SIG_WORD[{2'd3 - r.bidx[1:0], 3'b000} +: 8]);
                  fin = (r.bidx == 8'(SIG_LEN - 1));
                  okv = n.chk_ok;
                end
                OP_UNIQ:
                begin
                  // keep id, then check its inverse
                  if (r.bidx < 8'(UNIQ_LEN))
                    n.uniq_id[{r.bidx[3:0], 3'b000} +: 8] = b;
                  else
                    n.chk_ok = r.chk_ok && ((b ^ r.uniq_id[{r.bidx[3:0], 3'b000} +: 8]) == 8'hFF);
                  if (r.bidx == 8'(UNIQ_REC - 1))
                  begin
                    if (n.chk_ok || r.copy == 4'(UNIQ_COPIES - 1))
                    begin
                      fin = 1'b1;
                      okv = n.chk_ok;
                    end
                    else
                    begin
                      n.copy = r.copy + 4'h1;
                      n.bidx = 8'h00;
                      n.chk_ok = 1'b1;
                    end
                  end
                end
                OP_PARAM:
                begin
                  // checksum validates each copy
                  if (r.bidx < 8'(PP_CRC_LO))
                    n.crc = crc_step;
                  else if (r.bidx == 8'(PP_CRC_LO))
                    n.chk_ok = r.chk_ok && (b == r.crc[7:0]);
                  else
                    n.chk_ok = r.chk_ok && (b == r.crc[15:8]);
                  if (r.bidx == 8'(PP_CRC_HI))
                  begin
                    if (n.chk_ok || r.copy == 4'(PP_COPIES - 1))
                    begin
                      fin = 1'b1;
                      okv = n.chk_ok;
                    end
                    else
                    begin
                      n.copy = r.copy + 4'h1;
                      n.chk_ok = 1'b1;
                      n.crc = CRC_INIT;
                    end
                  end
                end
                default:
                begin
                  fin = 1'b1;
                  okv = 1'b1;
                end
              endcase
            end
          end
          else
            n.cnt = r.cnt + 16'h0001;
        end
        else
          n.ph = 2'd0;
      end
      S_RBWAIT:
      begin
        // reset done once ready/busy is released
        if (r.rb_s2)
        begin
          fin = 1'b1;
          okv = 1'b1;
          n.rst_busy = 1'b0;
        end
      end
      default:
        n.st = S_IDLE;
    endcase
    if (fin)
    begin
      n.st = S_IDLE;
      n.ph = 2'd0;
      n.pins.ce_n = 1'b1;
      n.res.done = 1'b1;
      n.res.rdy = 1'b1;
      n.res.ok = okv;
    end
  end

  // state register, frozen while enable is low
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.pins <= PINS_IDLE;
    end
    else if (en_i)
      r <= n;
  end

  assign res_o  = r.res;
  assign pins_o = r.pins;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  sig_length_a: assert property (r.st == S_READ && r.op == OP_SIG |-> r.bidx < 8'(SIG_LEN))
    else $error("signature read ran past four bytes");
  uniq_accept_a: assert property (r.res.done && r.op == OP_UNIQ && r.res.ok
                                  |-> r.chk_ok && r.bidx == 8'(UNIQ_REC))
    else $error("unique id accepted without a clean inverse");
  resume_cmd_a: assert property ($past(r.st) == S_POLL_RD && r.st == S_CMD
                                 |-> r.cmd == CMD_READ)
    else $error("status polling not followed by read command");
  poll_no_read_a: assert property (r.st == S_POLL_RD |=> r.st != S_READ)
    else $error("data read straight after status polling");
  crc_accept_a: assert property (r.res.done && r.op == OP_PARAM && r.res.ok |-> r.chk_ok)
    else $error("parameter page accepted with bad checksum");
  enh_addr_a: assert property (r.st == S_WAIT && $past(r.st) == S_ADR
                               && r.op == OP_STATUS_ENH |-> $past(r.aidx) == 2'(ADDR_ROW_CYC - 1))
    else $error("enhanced status without three row cycles");
  enh_reset_a: assert property (r.pins.cle && r.pins.io_out == CMD_STATUS_ENH
                                |-> !r.rst_busy)
    else $error("enhanced status during reset");
  pwr_quiet_a: assert property (r.st == S_PWR
                                |-> r.pins.ce_n && !r.pins.wp_n && !r.res.rdy)
    else $error("activity during power-up quiet time");

  uniq_done_c:  cover property (r.res.done && r.op == OP_UNIQ && r.res.ok);
  param_done_c: cover property (r.res.done && r.op == OP_PARAM && r.res.ok);
  reset_done_c: cover property (r.res.done && r.op == OP_RESET);
  enh_done_c:   cover property (r.res.done && r.op == OP_STATUS_ENH);

endmodule : nisr_top

// file: logic/nisr_pkg.sv
package nisr_pkg;

  // command bytes sent on the multiplexed bus
  localparam logic [7:0] CMD_READ       = 8'h00;
  localparam logic [7:0] CMD_ID         = 8'h90;
  localparam logic [7:0] CMD_UNIQ       = 8'hED;
  localparam logic [7:0] CMD_PARAM      = 8'hEC;
  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
  localparam logic [7:0] CMD_RESET      = 8'hFF;

  // address bytes for the identification reads
  localparam logic [7:0] ADDR_ID  = 8'h00;
  localparam logic [7:0] ADDR_SIG = 8'h20;
  localparam logic [7:0] ADDR_ZERO = 8'h00;
  localparam int unsigned ADDR_ROW_CYC = 3;

  // readout lengths
  localparam int unsigned ID_LEN      = 5;
  localparam int unsigned SIG_LEN     = 4;
  localparam logic [31:0] SIG_WORD    = 32'h4F4E4649;
  localparam int unsigned UNIQ_LEN    = 16;
  localparam int unsigned UNIQ_REC    = 32;
  localparam int unsigned UNIQ_COPIES = 16;
  localparam int unsigned PP_LEN      = 256;
  localparam int unsigned PP_COPIES   = 3;
  localparam int unsigned PP_CRC_LO   = 254;
  localparam int unsigned PP_CRC_HI   = 255;

  // integrity checksum, x^16+x^15+x^2+1
  localparam logic [15:0] CRC_INIT = 16'h4F4E;
  localparam logic [15:0] CRC_POLY = 16'h8005;

  // status byte fields
  localparam int unsigned ST_READY_BIT = 6;

  // timing, 10 MHz clock
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T_PWR_US      = 2000;
  localparam int unsigned PWR_CYC       = (T_PWR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_WB_NS       = 100;
  localparam int unsigned WB_CYC        = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RD_LOW_CYC    = 3;

  typedef enum logic [2:0] {
    OP_ID, OP_SIG, OP_UNIQ, OP_PARAM, OP_STATUS, OP_STATUS_ENH, OP_RESET
  } nisr_op_e;

  typedef enum logic [3:0] {
    S_PWR, S_IDLE, S_CMD, S_ADR, S_WAIT, S_POLL_RD, S_READ, S_RBWAIT
  } nisr_st_e;

  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       ce_n;
    logic       we_n;
    logic       re_n;
    logic       wp_n;
    logic [7:0] io_out;
    logic       io_oe;
  } nisr_pins_s;

  localparam nisr_pins_s PINS_IDLE = '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
                                       re_n: 1'b1, wp_n: 1'b0, io_out: 8'h00, io_oe: 1'b0};

  typedef struct packed {
    logic      go;
    nisr_op_e  op;
    logic [23:0] row;
  } nisr_req_s;

  typedef struct packed {
    logic       rdy;
    logic       byte_vld;
    logic [7:0] byte_val;
    logic       done;
    logic       ok;
  } nisr_res_s;

  typedef struct packed {
    nisr_st_e     st;
    nisr_st_e     nx;
    nisr_op_e     op;
    nisr_pins_s   pins;
    nisr_res_s    res;
    logic [7:0]   cmd;
    logic [23:0]  row;
    logic [15:0]  cnt;
    logic [1:0]   ph;
    logic [1:0]   aidx;
    logic [7:0]   bidx;
    logic [3:0]   copy;
    logic [127:0] uniq_id;
    logic         chk_ok;
    logic [15:0]  crc;
    logic         rst_busy;
    logic [7:0]   io_s1;
    logic [7:0]   io_s2;
    logic         rb_s1;
    logic         rb_s2;
  } nisr_state_s;

endpackage : nisr_pkg

// file: logic/nisr_crc16.sv
`timescale 1ns/10ps
module nisr_crc16
  import nisr_pkg::*;
(
  // running value and next byte
  input  wire logic [15:0] crc_i,
  input  wire logic [7:0]  byte_i,
  // updated value
  output logic      [15:0] crc_o
);

  // one byte, msb first, through the generator polynomial
  always_comb
  begin
    logic [15:0] c;
    c = crc_i;
    for (int i = 7; i >= 0; i--)
    begin
      if (c[15] ^ byte_i[i])
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      else
        c = {c[14:0], 1'b0};
    end
    crc_o = c;
  end

endmodule : nisr_crc16

// file: test/nisr_flash_model.sv
`timescale 1ns/10ps
module nisr_flash_model
  import nisr_pkg::*;
#(
  parameter logic [39:0]  P_ID       = 40'h6726_01C3_5A, // arbitrary id bytes
  parameter logic [127:0] P_UNIQ     = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210,
  parameter int           P_BUSY_NS  = 1500,
  parameter int           P_QUIET_NS = 1000
)
(
  // host pins
  input  wire nisr_pkg::nisr_pins_s pins_i,
  // bus and ready/busy
  output logic [7:0]                io_o,
  output logic                      rb_low_o,
  // fault injection and observation
  input  wire logic                 bad_i,
  input  wire logic [1:0]           fail_i,
  output logic                      viol_o,
  output logic [23:0]               row_o
);
  logic [7:0] page [256];
  logic [7:0] mode, lastv, drv;
  logic       smode, busy, sig;
  logic [9:0] ptr;
  logic [1:0] acnt, fail_r;
  logic [15:0] crc;
  event       kick;

  // power-up state and parameter page image with checksum
  initial
  begin
    {smode, busy, sig, viol_o, lastv, ptr, acnt, fail_r, mode, row_o} = '0;
    foreach (page[k]) page[k] = 8'h00;
    {page[0], page[1], page[2], page[3]} = SIG_WORD;
    page[4] = 8'h02;
    page[6] = 8'h10;
    page[8] = 8'h3B;
    page[64] = P_ID[7:0];
    page[81] = 8'h10;
    page[85] = 8'h01;
    page[92] = 8'h40;
    page[97] = 8'h08;
    page[100] = 8'h02;
    page[129] = 8'h1F;
    {page[134], page[133]} = 16'd900;
    {page[136], page[135]} = 16'd10000;
    {page[138], page[137]} = 16'd30;
    crc = CRC_INIT;
    for (int k = 0; k < 254; k++)
      for (int b = 7; b >= 0; b--)
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ page[k][b]) ? 16'h8005 : 16'h0000);
    {page[255], page[254]} = crc;
  end

  // array or reset busy time
  always
  begin
    @(kick);
    busy = 1'b1;
    #(P_BUSY_NS);
    busy = 1'b0;
  end

  // command and address latch on we rising edge
  always @(posedge pins_i.we_n)
  begin
    if (!pins_i.ce_n && pins_i.cle)
    begin
      if ($time < P_QUIET_NS)
        viol_o = 1'b1;
      if (busy && mode == CMD_RESET && pins_i.io_out == CMD_STATUS_ENH)
        viol_o = 1'b1;
      acnt = 2'd0;
      smode = pins_i.io_out == CMD_STATUS || pins_i.io_out == CMD_STATUS_ENH;
      if (pins_i.io_out == CMD_STATUS_ENH)
        fail_r = fail_i;
      if (pins_i.io_out == CMD_RESET)
        fail_r = 2'b00;
      if (!smode && pins_i.io_out != CMD_READ)
        mode = pins_i.io_out;
      if (pins_i.io_out == CMD_RESET)
        -> kick;
    end
    else if (!pins_i.ce_n && pins_i.ale)
    begin
      row_o[8*acnt +: 8] = pins_i.io_out;
      acnt = acnt + 2'd1;
      ptr = 10'd0;
      sig = pins_i.io_out == ADDR_SIG;
      if (mode == CMD_UNIQ || mode == CMD_PARAM)
        -> kick;
    end
  end

  // pointer moves on each completed data read
  always @(posedge pins_i.re_n)
  begin
    lastv = drv;
    if (!smode)
      ptr = ptr + 10'd1;
  end

  // byte offered on the bus
  always_comb
  begin
    if (smode)
      drv = {pins_i.wp_n, ~busy, ~busy, 3'b000, fail_r};
    else if (mode == CMD_UNIQ)
      drv = P_UNIQ[8*ptr[3:0] +: 8] ^ {8{ptr[4] ^ (bad_i && ptr == 10'd16)}};
    else if (mode == CMD_PARAM)
      drv = page[ptr[7:0]] ^ {7'd0, bad_i && ptr == 10'd254};
    else if (sig)
      drv = ptr < 4 ? SIG_WORD[31-8*ptr[1:0] -: 8] : 8'hA5 ^ ptr[7:0];
    else
      drv = ptr < 5 ? P_ID[8*ptr +: 8] : ~ptr[7:0];
  end

  // released bus shows the inverse of the last byte; open-drain busy
  assign io_o = (!pins_i.ce_n && !pins_i.re_n) ? drv : ~lastv;
  assign rb_low_o = busy;
endmodule : nisr_flash_model

// file: test/tb.sv
`timescale 1ns/10ps
module tb;
  import nisr_pkg::*;
  localparam logic [127:0] UNIQ_V = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  localparam logic [39:0]  ID_V   = 40'h6726_01C3_5A; // arbitrary id bytes
  logic        clk_i, rst_n_i, bad, rb_low, viol, en, en_q;
  logic [1:0]  fail;
  logic [7:0]  flash_io, io_i;
  logic [23:0] frow, row;
  logic [31:0] r32;
  nisr_req_s   req;
  nisr_res_s   res;
  nisr_pins_s  pins;
  logic [7:0]  exp_b [$];
  logic        exp_ok [$];
  int          n_errors, samples_checked, seed, cnt;

  nisr_top #(.P_PWR_CYC(10)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en),
    .req_i(req), .res_o(res), .pins_o(pins), .io_i(io_i), .rb_i(~rb_low));
  nisr_flash_model #(.P_ID(ID_V), .P_UNIQ(UNIQ_V)) i_flash (.pins_i(pins), .io_o(flash_io),
    .rb_low_o(rb_low), .bad_i(bad), .fail_i(fail), .viol_o(viol), .row_o(frow));

  // shared bus level
  assign io_i = pins.io_oe ? pins.io_out : flash_io;

  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run;
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic wait_for(input int lim, input bit want_rdy);
    cnt = 0;
    while ((want_rdy ? res.rdy : res.done) !== 1'b1 && cnt < lim)
    begin
      en = want_rdy || ($random(seed) % 4 != 0); // freeze now and then mid-operation
      @(negedge clk_i);
      cnt++;
    end
    en = 1'b1;
    if (cnt >= lim)
    begin
      n_errors++;
      complete_run();
    end
  endtask : wait_for

  task automatic run_op(input nisr_op_e op, input logic [23:0] r, input bit poke);
    wait_for(4000, 1'b1);
    exp_ok.push_back(1'b1);
    req = '{go: 1'b1, op: op, row: r};
    @(negedge clk_i);
    req.go = 1'b0;
    if (poke)
    begin
      @(negedge clk_i);
      req = '{go: 1'b1, op: OP_RESET, row: 24'h0}; // ignored while busy
      @(negedge clk_i);
      req.go = 1'b0;
    end
    wait_for(8000, 1'b0);
    @(negedge clk_i);
  endtask : run_op

  task automatic push_status(input logic [1:0] f);
    exp_b.push_back({3'b111, 3'b000, f});
  endtask : push_status

  // enable seen at the last edge: a frozen pulse is not a new result
  always @(posedge clk_i)
    en_q <= en;

  // results against the oldest notes
  always @(negedge clk_i)
  begin
    if (res.byte_vld === 1'b1 && en_q === 1'b1)
      check(res.byte_val, exp_b.size() ? exp_b.pop_front() : ~res.byte_val);
    if (res.done === 1'b1 && en_q === 1'b1)
      check(res.ok, exp_ok.size() ? exp_ok.pop_front() : ~res.ok);
  end

  // main sequence
  initial
  begin
    seed = 32'h6667;
    n_errors = 0;
    samples_checked = 0;
    {rst_n_i, bad, fail} = '0;
    en = 1'b1;
    req = '0;
    repeat (3) @(negedge clk_i);
    check({pins.wp_n, pins.ce_n, res.rdy}, 3'b010);
    rst_n_i = 1'b1;
    wait_for(100, 1'b1);
    check(cnt >= 10, 1'b1);
    for (int i = 0; i < 5; i++) exp_b.push_back(ID_V[8*i +: 8]);
    run_op(OP_ID, 24'h0, 1'b0);
    for (int i = 0; i < 4; i++) exp_b.push_back(SIG_WORD[31-8*i -: 8]);
    run_op(OP_SIG, 24'h0, 1'b0);
    push_status(2'b00);
    run_op(OP_STATUS, 24'h0, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      r32 = $random(seed);
      row = r32[23:0];
      fail = r32[25:24];
      push_status(fail);
      run_op(OP_STATUS_ENH, row, 1'b0);
      check(frow, row);
    end
    check(exp_b.size(), 24'd0);
    run_op(OP_RESET, 24'h0, 1'b0);
    push_status(2'b00);
    run_op(OP_STATUS, 24'h0, 1'b0);
    for (int c = 0; c < 2; c++)
    begin
      bad = c[0];
      for (int i = 0; i < 32 * (c + 1); i++)
        exp_b.push_back(UNIQ_V[8*(i%16) +: 8] ^ {8{(i%32) >= 16 && !(bad && i == 16)}});
      run_op(OP_UNIQ, 24'h0, 1'b1);
      for (int i = 0; i < 256 * (c + 1); i++)
        exp_b.push_back(i_flash.page[i%256] ^ {7'd0, bad && i == 254});
      run_op(OP_PARAM, 24'h0, 1'b0);
    end
    check(viol, 1'b0);
    check(exp_b.size() + exp_ok.size(), 24'd0);
    complete_run();
  end
endmodule : tb
